//--- include/lpc_pkg.sv
// Shared constants, types and helpers for the memory channel link.
package lpc_pkg;
    // ==========================================================
    // Widths
    localparam int CA_W = 10;
    localparam int DQ_W = 32;
    localparam int LANES = 4;
    localparam int ADDR_W = 4;
    localparam int WORDS = 16;
    // ==========================================================
    // Link clock phases, counted in system clock cycles
    localparam logic [3:0] PH_CA_FALL = 4'h4;
    localparam logic [3:0] PH_DQS_HIGH = 4'h4;
    localparam logic [3:0] PH_CA_RISE = 4'hc;
    localparam int CAP_DELAY = 4;
    // ==========================================================
    // Command codes carried in the rising-edge half of the bus
    localparam logic [1:0] OP_NOP = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    // ==========================================================
    // Values after reset
    localparam logic OE_OFF_N = 1'b1;
    localparam logic CS_IDLE_N = 1'b1;
    localparam logic CKE_RST = 1'b0;
    localparam logic [3:0] DQS_OE_OFF_N = 4'hf;
    // ==========================================================
    // States
    typedef enum logic {
        LPC_ACTIVE = 1'b0,
        LPC_DOWN = 1'b1
    } lpc_pwr_t;
    typedef enum logic [1:0] {
        LPC_IDLE = 2'b00,
        LPC_WDATA = 2'b01,
        LPC_RWAIT = 2'b10
    } lpc_ctl_st_t;
    // ==========================================================
    // Byte lane n of a data word.
    function automatic logic [7:0] lpc_lane(input logic [31:0] w,
                                            input int n);
        return w[n*8 +: 8];
    endfunction
endpackage

//--- include/lpc_link_if.sv
// Pin bundle of one memory channel between controller and memory.
`timescale 1ns/10ps
interface lpc_link_if;
    logic ck_t;
    logic ck_c;
    logic cke;
    logic cs_n;
    logic odt;
    logic [9:0] ca;
    logic [3:0] dm;
    logic [31:0] ctl_dq_o;
    logic ctl_dq_oe_n;
    logic [31:0] mem_dq_o;
    logic mem_dq_oe_n;
    logic [31:0] dq;
    logic [3:0] ctl_dqs_t_o;
    logic [3:0] ctl_dqs_c_o;
    logic [3:0] ctl_dqs_oe_n;
    logic [3:0] mem_dqs_t_o;
    logic [3:0] mem_dqs_c_o;
    logic [3:0] mem_dqs_oe_n;
    logic [3:0] dqs_t;
    logic [3:0] dqs_c;
    // ==========================================================
    // Wire resolution: an undriven line reads low.
    assign dq = ({32{~mem_dq_oe_n}} & mem_dq_o) |
                ({32{~ctl_dq_oe_n}} & ctl_dq_o);
    assign dqs_t = (~mem_dqs_oe_n & mem_dqs_t_o) |
                   (~ctl_dqs_oe_n & ctl_dqs_t_o);
    assign dqs_c = (~mem_dqs_oe_n & mem_dqs_c_o) |
                   (~ctl_dqs_oe_n & ctl_dqs_c_o);
    modport ctl (
        output ck_t, ck_c, cke, cs_n, odt, ca, dm,
        output ctl_dq_o, ctl_dq_oe_n, ctl_dqs_t_o, ctl_dqs_c_o,
        output ctl_dqs_oe_n,
        input dq, dqs_t, dqs_c
    );
    modport mem (
        input ck_t, ck_c, cke, cs_n, odt, ca, dm, dq, dqs_t, dqs_c,
        output mem_dq_o, mem_dq_oe_n, mem_dqs_t_o, mem_dqs_c_o,
        output mem_dqs_oe_n
    );
endinterface

//--- logic/lpc_pair_buf.sv
// Two-entry valid/ready buffer for returned read words.
`timescale 1ns/10ps
module lpc_pair_buf #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    input wire logic sys_clk_in, // System clock.
    input wire logic srst_in, // Synchronous reset.
    input wire logic in_valid_in, // Word offered.
    output logic in_ready_out, // Room for a word.
    input wire logic [WIDTH-1:0] in_data_in, // Offered word.
    output logic out_valid_out, // Word available.
    input wire logic out_ready_in, // Consumer takes word.
    output logic [WIDTH-1:0] out_data_out // Oldest word.
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] cnt;
    } lpc_buf_t;

    lpc_buf_t r;
    lpc_buf_t n;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
        return (p == LAST) ? '0 : p + PW'(1);
    endfunction

    assign in_ready_out = (r.cnt != FULL);
    assign out_valid_out = (r.cnt != '0);
    assign out_data_out = r.mem[r.rp];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb
    begin
        n = r;
        if (push)
        begin
            n.mem[r.wp] = in_data_in;
            n.wp = step(r.wp);
        end
        if (pop)
        begin
            n.rp = step(r.rp);
        end
        n.cnt = r.cnt + CW'(push) - CW'(pop);
        if (srst_in)
        begin
            n = '0;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        r <= n;
    end
endmodule

//--- logic/lpc_mem_end.sv
// Memory end of one channel: pin sampling, decode, data and strobes.
`timescale 1ns/10ps
module lpc_mem_end (
    input wire logic sys_clk_in, // System clock, 200 MHz.
    input wire logic srst_in, // Synchronous reset, high.
    lpc_link_if.mem link, // Pins of this channel.
    input wire logic odt_en_in, // Termination allowed by settings.
    output logic pwr_down_out, // Memory in power-down.
    output logic term_on_out, // On-die termination active.
    output logic cmd_valid_out, // Pulse: command decoded.
    output logic [1:0] cmd_op_out, // Decoded command code.
    output logic [3:0] cmd_addr_out // Decoded word address.
);
    // ==========================================================
    // State
    typedef struct packed {
        logic ck_s1;
        logic ck_s2;
        logic ck_s3;
        logic cke_s1;
        logic cke_s2;
        logic cs_n_s1;
        logic cs_n_s2;
        logic odt_s1;
        logic odt_s2;
        logic [9:0] ca_s1;
        logic [9:0] ca_s2;
        logic [3:0] dm_s1;
        logic [3:0] dm_s2;
        logic [31:0] dq_s1;
        logic [31:0] dq_s2;
        logic [3:0] dqs_s1;
        logic [3:0] dqs_s2;
        logic [3:0] dqs_s3;
        lpc_pkg::lpc_pwr_t pwr;
        logic [9:0] rise_ca;
        logic pend;
        logic wr_arm;
        logic rd_arm;
        logic rd_drv;
        logic [3:0] addr;
        logic [31:0] dq_o;
        logic dq_oe_n;
        logic [3:0] dqs_o;
        logic [3:0] dqs_oe_n;
        logic [lpc_pkg::WORDS-1:0][31:0] mem;
        logic cmd_v;
        logic [1:0] cmd_op;
        logic [3:0] cmd_addr;
        logic term;
    } lpc_mem_t;

    lpc_mem_t r;
    lpc_mem_t n;
    logic ck_rise;
    logic ck_fall;
    logic [3:0] dqs_rise;

    // Edges are judged on the second and third synchroniser stages, so that
    // a metastable first stage never reaches the decode.
    assign ck_rise = r.ck_s2 && !r.ck_s3;
    assign ck_fall = !r.ck_s2 && r.ck_s3;
    assign dqs_rise = r.dqs_s2 & ~r.dqs_s3;

    // ==========================================================
    // Next state
    always_comb
    begin
        n = r;
        n.ck_s1 = link.ck_t;
        n.ck_s2 = r.ck_s1;
        n.ck_s3 = r.ck_s2;
        n.cke_s1 = link.cke;
        n.cke_s2 = r.cke_s1;
        n.cs_n_s1 = link.cs_n;
        n.cs_n_s2 = r.cs_n_s1;
        n.odt_s1 = link.odt;
        n.odt_s2 = r.odt_s1;
        n.ca_s1 = link.ca;
        n.ca_s2 = r.ca_s1;
        n.dm_s1 = link.dm;
        n.dm_s2 = r.dm_s1;
        n.dq_s1 = link.dq;
        n.dq_s2 = r.dq_s1;
        n.dqs_s1 = link.dqs_t;
        n.dqs_s2 = r.dqs_s1;
        n.dqs_s3 = r.dqs_s2;
        n.cmd_v = 1'b0;

        if (ck_rise)
        begin
            if (r.cke_s2)
            begin
                n.pwr = lpc_pkg::LPC_ACTIVE;
                n.pend = 1'b0;
                // A deselected edge carries no command at all.
                if (!r.cs_n_s2)
                begin
                    n.rise_ca = r.ca_s2;
                    n.pend = 1'b1;
                end
                if (r.rd_drv)
                begin
                    n.dq_oe_n = lpc_pkg::OE_OFF_N;
                    n.dqs_oe_n = lpc_pkg::DQS_OE_OFF_N;
                    n.rd_drv = 1'b0;
                end
                if (r.rd_arm)
                begin
                    // Data and strobe change together on a read.
                    n.dq_o = r.mem[r.addr];
                    n.dqs_o = 4'hf;
                    n.dq_oe_n = 1'b0;
                    n.dqs_oe_n = 4'h0;
                    n.rd_drv = 1'b1;
                    n.rd_arm = 1'b0;
                end
            end
            else
            begin
                // Everything halts; a transfer under way is dropped.
                n.pwr = lpc_pkg::LPC_DOWN;
                n.pend = 1'b0;
                n.rd_arm = 1'b0;
                n.wr_arm = 1'b0;
                n.rd_drv = 1'b0;
                n.dq_oe_n = lpc_pkg::OE_OFF_N;
                n.dqs_oe_n = lpc_pkg::DQS_OE_OFF_N;
            end
        end

        if (ck_fall)
        begin
            n.wr_arm = 1'b0;
            if (r.rd_drv)
            begin
                n.dqs_o = 4'h0;
            end
            if (r.pend && r.pwr == lpc_pkg::LPC_ACTIVE)
            begin
                // Second half of the command arrives on this edge.
                n.pend = 1'b0;
                n.cmd_v = 1'b1;
                n.cmd_op = r.rise_ca[1:0];
                n.cmd_addr = r.ca_s2[3:0];
                n.addr = r.ca_s2[3:0];
                n.wr_arm = (r.rise_ca[1:0] == lpc_pkg::OP_WRITE);
                n.rd_arm = (r.rise_ca[1:0] == lpc_pkg::OP_READ);
            end
        end

        // Each lane is caught on its own strobe, unless masked.
        for (int b = 0; b < lpc_pkg::LANES; b++)
        begin
            if (r.wr_arm && dqs_rise[b] && !r.dm_s2[b])
            begin
                n.mem[r.addr][b*8 +: 8] = lpc_pkg::lpc_lane(r.dq_s2, b);
            end
        end

        n.term = r.odt_s2 && odt_en_in &&
                 (r.pwr == lpc_pkg::LPC_ACTIVE);

        if (srst_in)
        begin
            n = '0;
            n.pwr = lpc_pkg::LPC_DOWN;
            // Synchronisers start at the pins' reset levels, so that no
            // false clock edge is seen as reset ends.
            n.ck_s1 = 1'b1;
            n.ck_s2 = 1'b1;
            n.ck_s3 = 1'b1;
            n.cs_n_s1 = lpc_pkg::CS_IDLE_N;
            n.cs_n_s2 = lpc_pkg::CS_IDLE_N;
            n.dq_oe_n = lpc_pkg::OE_OFF_N;
            n.dqs_oe_n = lpc_pkg::DQS_OE_OFF_N;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        r <= n;
    end

    // ==========================================================
    // Outputs
    // One instance serves one channel; a second channel is simply a
    // second instance on its own pin bundle.
    assign link.mem_dq_o = r.dq_o;
    assign link.mem_dq_oe_n = r.dq_oe_n;
    assign link.mem_dqs_t_o = r.dqs_o;
    assign link.mem_dqs_c_o = ~r.dqs_o;
    assign link.mem_dqs_oe_n = r.dqs_oe_n;
    assign pwr_down_out = (r.pwr == lpc_pkg::LPC_DOWN);
    assign term_on_out = r.term;
    assign cmd_valid_out = r.cmd_v;
    assign cmd_op_out = r.cmd_op;
    assign cmd_addr_out = r.cmd_addr;
endmodule

//--- logic/lpc_ctl_end.sv
// Controller end of one channel: clock, commands, write and read data.
`timescale 1ns/10ps
module lpc_ctl_end (
    input wire logic sys_clk_in, // System clock, 200 MHz.
    input wire logic srst_in, // Synchronous reset, high.
    lpc_link_if.ctl link, // Pins of this channel.
    input wire logic req_valid_in, // Request offered.
    output logic req_ready_out, // Request taken this cycle.
    input wire logic req_write_in, // 1 write, 0 read.
    input wire logic [3:0] req_addr_in, // Word address.
    input wire logic [31:0] req_wdata_in, // Write data.
    input wire logic [3:0] req_mask_in, // Write byte masks.
    input wire logic odt_in, // Termination wanted.
    input wire logic pwr_down_in, // Power-down wanted.
    output logic pwr_down_out, // Clock enable is low.
    output logic rd_valid_out, // Read word available.
    input wire logic rd_ready_in, // Read word taken.
    output logic [31:0] rd_data_out // Read word.
);
    typedef struct packed {
        logic [3:0] ph;
        lpc_pkg::lpc_ctl_st_t st;
        logic ck;
        logic cke;
        logic cs_n;
        logic odt;
        logic [9:0] ca;
        logic [9:0] fall_ca;
        logic [3:0] dm;
        logic [31:0] wdata;
        logic [3:0] wmask;
        logic [31:0] dq;
        logic dq_oe_n;
        logic [3:0] dqs;
        logic [3:0] dqs_oe_n;
        logic [3:0] dqs_s1;
        logic [3:0] dqs_s2;
        logic [3:0] dqs_s3;
        logic [31:0] dq_s1;
        logic [31:0] dq_s2;
        logic [lpc_pkg::CAP_DELAY-1:0][3:0] dly;
        logic [31:0] rdata;
        logic [3:0] got;
    } lpc_ctl_t;

    lpc_ctl_t r;
    lpc_ctl_t n;
    logic buf_in_ready;
    logic push;

    // A read is only issued while the buffer has room, so a stalled
    // consumer holds off new reads instead of losing a returned word.
    assign req_ready_out = (r.ph == lpc_pkg::PH_CA_RISE) &&
                           (r.st == lpc_pkg::LPC_IDLE) && r.cke &&
                           (pwr_down_in != r.cke) &&
                           (req_write_in || buf_in_ready);
    assign push = (r.st == lpc_pkg::LPC_RWAIT) && (&r.got);

    always_comb
    begin
        n = r;
        n.ph = r.ph + 4'h1;
        n.ck = ~n.ph[3];
        n.dqs_s1 = link.dqs_t;
        n.dqs_s2 = r.dqs_s1;
        n.dqs_s3 = r.dqs_s2;
        n.dq_s1 = link.dq;
        n.dq_s2 = r.dq_s1;
        n.dly = {r.dly[lpc_pkg::CAP_DELAY-2:0], r.dqs_s2 & ~r.dqs_s3};

        // Read data is edge-aligned, so sample a quarter period late.
        for (int b = 0; b < lpc_pkg::LANES; b++)
        begin
            if (r.st == lpc_pkg::LPC_RWAIT &&
                r.dly[lpc_pkg::CAP_DELAY-1][b])
            begin
                n.rdata[b*8 +: 8] = lpc_pkg::lpc_lane(r.dq_s2, b);
                n.got[b] = 1'b1;
            end
        end
        if (push && buf_in_ready)
        begin
            n.st = lpc_pkg::LPC_IDLE;
        end

        if (r.ph == lpc_pkg::PH_CA_FALL)
        begin
            n.ca = r.fall_ca;
            if (r.st == lpc_pkg::LPC_WDATA && !r.dq_oe_n)
            begin
                n.dqs = 4'hf;
            end
        end

        if (r.ph == lpc_pkg::PH_CA_RISE)
        begin
            n.cs_n = lpc_pkg::CS_IDLE_N;
            n.ca = '0;
            if (r.st == lpc_pkg::LPC_WDATA)
            begin
                n.dqs = 4'h0;
                if (r.dq_oe_n)
                begin
                    n.dq = r.wdata;
                    n.dm = r.wmask;
                    n.dq_oe_n = 1'b0;
                    n.dqs_oe_n = 4'h0;
                end
                else
                begin
                    n.dq_oe_n = lpc_pkg::OE_OFF_N;
                    n.dqs_oe_n = lpc_pkg::DQS_OE_OFF_N;
                    n.dm = 4'h0;
                    n.st = lpc_pkg::LPC_IDLE;
                end
            end
            else if (r.st == lpc_pkg::LPC_IDLE)
            begin
                n.odt = odt_in;
                if (pwr_down_in == r.cke)
                begin
                    // Entry or exit rides on a deselected command slot.
                    n.cke = ~pwr_down_in;
                end
                else if (req_ready_out && req_valid_in)
                begin
                    n.cs_n = 1'b0;
                    n.ca = {8'h00, req_write_in ? lpc_pkg::OP_WRITE :
                                                  lpc_pkg::OP_READ};
                    n.fall_ca = {6'h00, req_addr_in};
                    n.wdata = req_wdata_in;
                    n.wmask = req_mask_in;
                    n.got = 4'h0;
                    n.st = req_write_in ? lpc_pkg::LPC_WDATA :
                                          lpc_pkg::LPC_RWAIT;
                end
            end
        end

        if (srst_in)
        begin
            n = '0;
            n.ck = 1'b1;
            n.cke = lpc_pkg::CKE_RST;
            n.cs_n = lpc_pkg::CS_IDLE_N;
            n.dq_oe_n = lpc_pkg::OE_OFF_N;
            n.dqs_oe_n = lpc_pkg::DQS_OE_OFF_N;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        r <= n;
    end

    lpc_pair_buf #(
        .WIDTH(32),
        .DEPTH(2)
    ) lpc_pair_buf_inst (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .in_valid_in(push),
        .in_ready_out(buf_in_ready),
        .in_data_in(r.rdata),
        .out_valid_out(rd_valid_out),
        .out_ready_in(rd_ready_in),
        .out_data_out(rd_data_out)
    );

    assign link.ck_t = r.ck;
    assign link.ck_c = ~r.ck;
    assign link.cke = r.cke;
    assign link.cs_n = r.cs_n;
    assign link.odt = r.odt;
    assign link.ca = r.ca;
    assign link.dm = r.dm;
    assign link.ctl_dq_o = r.dq;
    assign link.ctl_dq_oe_n = r.dq_oe_n;
    assign link.ctl_dqs_t_o = r.dqs;
    assign link.ctl_dqs_c_o = ~r.dqs;
    assign link.ctl_dqs_oe_n = r.dqs_oe_n;
    assign pwr_down_out = ~r.cke;
endmodule

//--- tb/lpc_link_assertions.sv
// Concurrent checks on the pins of one memory channel.
`timescale 1ns/10ps
module lpc_link_assertions (
    input wire logic sys_clk_in, // System clock.
    input wire logic srst_in, // Synchronous reset, high.
    input wire logic ck_t, // Link clock, true.
    input wire logic ck_c, // Link clock, complement.
    input wire logic cke, // Clock enable.
    input wire logic cs_n, // Chip select, low active.
    input wire logic [9:0] ca, // Command/address.
    input wire logic [3:0] dm, // Write byte masks.
    input wire logic ctl_dq_oe_n, // Controller drives data when low.
    input wire logic mem_dq_oe_n, // Memory drives data when low.
    input wire logic [31:0] dq, // Resolved data bus.
    input wire logic [3:0] ctl_dqs_oe_n, // Controller strobe enables.
    input wire logic [3:0] mem_dqs_oe_n, // Memory strobe enables.
    input wire logic [3:0] dqs_t // Resolved strobes, true.
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (srst_in);
    // ==========================================================
    // Link clock shape
    sequence ck_high_half;
        ck_t [*8];
    endsequence
    sequence ck_low_half;
        !ck_t [*8];
    endsequence
    clk_period_a: assert property (
        $rose(ck_t) |-> ck_high_half ##1 ck_low_half ##1 ck_t)
        else $error("Link clock period is not 16 cycles.");
    clk_compl_a: assert property (ck_c == !ck_t)
        else $error("Link clock halves are not complementary.");
    // ==========================================================
    // Command pins
    ca_edge_stable_a: assert property (
        $changed(ck_t) |-> $stable(ca))
        else $error("Command bus changed on a link clock edge.");
    sel_low_phase_a: assert property (
        ($changed(cs_n) || $changed(cke)) |-> !ck_t)
        else $error("Select or enable changed while clock high.");
    cmd_code_a: assert property (
        ($rose(ck_t) && !cs_n) |-> (ca[1:0] == lpc_pkg::OP_WRITE ||
        ca[1:0] == lpc_pkg::OP_READ))
        else $error("Selected rising edge carries no valid code.");
    pd_deselect_a: assert property (
        ($changed(cke) || !cke) |-> cs_n)
        else $error("Chip selected during power state change.");
    // ==========================================================
    // Data and strobes
    one_dq_driver_a: assert property (
        !(!ctl_dq_oe_n && !mem_dq_oe_n))
        else $error("Both ends drive the data bus.");
    one_dqs_driver_a: assert property (
        (~ctl_dqs_oe_n & ~mem_dqs_oe_n) == 4'h0)
        else $error("Both ends drive a strobe.");
    mask_with_data_a: assert property (
        (dm != 4'h0) |-> !ctl_dq_oe_n)
        else $error("Mask raised without write data.");
    wr_centred_a: assert property (
        (ctl_dqs_oe_n == 4'h0 && $rose(dqs_t[0])) |->
        ($past(dq, 4) == dq) ##1 $stable(dq) [*4])
        else $error("Write strobe edge not inside the data eye.");
    rd_edge_a: assert property (
        (!mem_dqs_oe_n[0] && $rose(dqs_t[0])) |-> !mem_dq_oe_n)
        else $error("Read strobe edge without read data.");
    rd_release_a: assert property (
        $fell(mem_dq_oe_n) |-> ##[1:24] $rose(mem_dq_oe_n))
        else $error("Memory holds the data bus too long.");
endmodule

//--- tb/lpddr3_channel_pin_interface_bench.sv
// Self-checking bench joining controller and memory ends of a channel.
`timescale 1ns/10ps
module lpddr3_channel_pin_interface_bench;
    localparam logic [31:0] BASE = 32'h11223344;
    logic sys_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic req_valid_in = 1'b0;
    logic req_write_in = 1'b0;
    logic [3:0] req_addr_in = 4'h0;
    logic [31:0] req_wdata_in = 32'h0;
    logic [3:0] req_mask_in = 4'h0;
    logic odt_in = 1'b0;
    logic odt_en_in = 1'b0;
    logic pwr_down_in = 1'b0;
    logic rd_ready_in = 1'b0;
    logic req_ready_out, ctl_pd, mem_pd, rd_valid_out, term_on_out;
    logic cmd_valid_out;
    logic [1:0] cmd_op_out;
    logic [3:0] cmd_addr_out;
    logic [31:0] rd_data_out, exp_w;
    logic t;
    int mismatches = 0;
    int samples_checked = 0;
    int cmds_sent = 0;
    int cmds_seen = 0;
    int n;
    always
    begin
        #2.5 sys_clk_in = ~sys_clk_in;
    end
    lpc_link_if link_if ();
    lpc_ctl_end lpc_ctl_end_inst (.sys_clk_in, .srst_in,
        .link(link_if.ctl), .req_valid_in, .req_ready_out, .req_write_in,
        .req_addr_in, .req_wdata_in, .req_mask_in, .odt_in, .pwr_down_in,
        .pwr_down_out(ctl_pd), .rd_valid_out, .rd_ready_in, .rd_data_out);
    lpc_mem_end lpc_mem_end_inst (.sys_clk_in, .srst_in,
        .link(link_if.mem), .odt_en_in, .pwr_down_out(mem_pd),
        .term_on_out, .cmd_valid_out, .cmd_op_out, .cmd_addr_out);
    lpc_link_assertions lpc_link_assertions_inst (.sys_clk_in, .srst_in,
        .ck_t(link_if.ck_t), .ck_c(link_if.ck_c), .cke(link_if.cke),
        .cs_n(link_if.cs_n), .ca(link_if.ca), .dm(link_if.dm),
        .ctl_dq_oe_n(link_if.ctl_dq_oe_n), .dq(link_if.dq),
        .mem_dq_oe_n(link_if.mem_dq_oe_n), .dqs_t(link_if.dqs_t),
        .ctl_dqs_oe_n(link_if.ctl_dqs_oe_n),
        .mem_dqs_oe_n(link_if.mem_dqs_oe_n));
    always @(posedge sys_clk_in)
    begin
        if (cmd_valid_out === 1'b1)
            cmds_seen <= cmds_seen + 1;
    end
    // ==========================================================
    // Compare and access tasks
    task automatic chk_word(input string name, input logic [31:0] exp,
                            input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_bit(input string name, input logic exp,
                           input logic got);
        chk_word(name, {31'h0, exp}, {31'h0, got});
    endtask
    task automatic send(input logic wr, input logic [3:0] addr,
                        input logic [31:0] data, input logic [3:0] mask,
                        output logic taken);
        int i;
        logic [1:0] exp_op;
        taken = 1'b0;
        exp_op = wr ? lpc_pkg::OP_WRITE : lpc_pkg::OP_READ;
        @(negedge sys_clk_in);
        req_valid_in = 1'b1;
        req_write_in = wr;
        req_addr_in = addr;
        req_wdata_in = data;
        req_mask_in = mask;
        for (i = 0; i < 80; i++)
        begin
            if (req_ready_out === 1'b1)
            begin
                taken = 1'b1;
                break;
            end
            @(negedge sys_clk_in);
        end
        @(negedge sys_clk_in);
        req_valid_in = 1'b0;
        if (taken)
        begin
            cmds_sent++;
            for (i = 0; i < 40 && cmd_valid_out !== 1'b1; i++)
                @(negedge sys_clk_in);
            chk_bit("cmd_valid", 1'b1, cmd_valid_out);
            chk_word("cmd_op", {30'h0, exp_op}, {30'h0, cmd_op_out});
            chk_word("cmd_addr", {28'h0, addr}, {28'h0, cmd_addr_out});
        end
    endtask
    task automatic pop(input logic [31:0] exp);
        int i;
        // An edge passes first, so back-to-back pops never drop and raise
        // the ready in one time step.
        @(negedge sys_clk_in);
        for (i = 0; i < 100 && rd_valid_out !== 1'b1; i++)
            @(negedge sys_clk_in);
        chk_bit("rd_valid", 1'b1, rd_valid_out);
        chk_word("rd_data", exp, rd_data_out);
        rd_ready_in = 1'b1;
        @(negedge sys_clk_in);
        rd_ready_in = 1'b0;
    endtask
    task automatic wr(input logic [3:0] addr, input logic [31:0] data,
                      input logic [3:0] mask);
        logic tk;
        send(1'b1, addr, data, mask, tk);
    endtask
    task automatic rd(input logic [3:0] addr, input logic [31:0] exp);
        logic tk;
        send(1'b0, addr, 32'h0, 4'h0, tk);
        pop(exp);
    endtask
    task automatic wait_state(input logic pd, input logic term);
        int i;
        for (i = 0; i < 100; i++)
        begin
            if (ctl_pd === pd && mem_pd === pd && term_on_out === term)
                break;
            @(negedge sys_clk_in);
        end
        chk_bit("ctl_pd", pd, ctl_pd);
        chk_bit("mem_pd", pd, mem_pd);
        chk_bit("term_on", term, term_on_out);
    endtask
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial
    begin
        repeat (10) @(negedge sys_clk_in);
        chk_bit("mem_pd_rst", 1'b1, mem_pd);
        chk_bit("cke_rst", 1'b0, link_if.cke);
        chk_bit("cs_rst", 1'b1, link_if.cs_n);
        srst_in = 1'b0;
        wait_state(1'b0, 1'b0);
        rd(4'h5, 32'h0);
        $display("Test reset done");
        for (n = 0; n < 4; n++)
        begin
            wr(n[3:0], BASE, 4'h0);
            wr(n[3:0], 32'haabbccdd, 4'h1 << n);
            exp_w = 32'haabbccdd;
            exp_w[n*8 +: 8] = BASE[n*8 +: 8];
            rd(n[3:0], exp_w);
        end
        wr(4'hf, 32'h5a5aa5a5, 4'h0);
        wr(4'hf, 32'hffffffff, 4'hf);
        rd(4'hf, 32'h5a5aa5a5);
        $display("Test write masks done");
        // The consumer stalls so both entries fill and a third is held off.
        send(1'b0, 4'hf, 32'h0, 4'h0, t);
        send(1'b0, 4'h0, 32'h0, 4'h0, t);
        send(1'b0, 4'h1, 32'h0, 4'h0, t);
        chk_bit("full_refused", 1'b0, t);
        pop(32'h5a5aa5a5);
        pop(32'haabbcc44);
        chk_bit("buf_empty", 1'b0, rd_valid_out);
        $display("Test buffer done");
        odt_in = 1'b1;
        odt_en_in = 1'b1;
        wait_state(1'b0, 1'b1);
        odt_en_in = 1'b0;
        wait_state(1'b0, 1'b0);
        odt_en_in = 1'b1;
        pwr_down_in = 1'b1;
        wait_state(1'b1, 1'b0);
        chk_bit("cke_low", 1'b0, link_if.cke);
        send(1'b1, 4'h2, 32'h0, 4'h0, t);
        chk_bit("pd_refused", 1'b0, t);
        pwr_down_in = 1'b0;
        wait_state(1'b0, 1'b1);
        rd(4'h2, 32'haa22ccdd);
        $display("Test power and termination done");
        srst_in = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        chk_bit("mem_pd_rst2", 1'b1, mem_pd);
        chk_bit("term_rst", 1'b0, term_on_out);
        odt_in = 1'b0;
        srst_in = 1'b0;
        wait_state(1'b0, 1'b0);
        rd(4'h2, 32'h0);
        chk_word("cmd_count", cmds_sent, cmds_seen);
        $display("Test second reset done");
        print_verdict;
    end
    initial
    begin
        #100000;
        mismatches++;
        $display("Watchdog expired");
        print_verdict;
    end
endmodule
